// ### verilog/lpa_regs.sv
// Notes on behaviour
// - Access register clears on power-up and soft reset
// - Read request bit issues read, then clears
// - Write request bit issues write, then clears
// - Four-bit target address for both requests
// - Eight-bit value sent by write requests
// - Capture returned address from read answer
// - Capture returned value from read answer
// - Returned fields writable only under override
// - Matching response label and code is steered
// - Expected label resets to zero
// - Expected code resets ones; ones disables match
// - FIFO status clears on all resets
// - Full flag when FIFO holds capacity
// - Near-full flag when FIFO nearly full
// - Flag when four locations are free
// - Near-empty flag when FIFO nearly empty
// - Empty flag; forced one by resets
// - Status flags host-writable under override
// - Flush bit empties FIFO, self-clears
// - Seven-bit capacity, resets to twenty quadlets
// - Override bit opens configurable read-only fields
//
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/1ns
`default_nettype none
`include "lpa_defs.svh"

module lpa_regs #(
  parameter int ADDR_W         = 8,
  parameter int CAP_W          = 7,
  parameter int NEAR_FULL_GAP  = 1,
  parameter int NEAR_EMPTY_GAP = 1
) (
  // Clock and reset
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  // Register bus write side
  input  wire logic [ADDR_W-1:0]    s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  // Register bus read side
  input  wire logic [ADDR_W-1:0]    s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  // Reset events
  input  wire logic                 sw_reset,
  input  wire logic                 bus_reset,
  // Physical-layer register access
  output lpa_pkg::lpa_phy_req_t     phy_req,
  input  wire logic                 phy_req_ready,
  input  wire lpa_pkg::lpa_phy_rsp_t phy_rsp,
  // Response filter
  input  wire lpa_pkg::lpa_rsp_pkt_t rsp_pkt,
  output logic                      rsp_match,
  // Transmit FIFO control and status
  input  wire logic [CAP_W-1:0]     fifo_level,
  output logic                      txfifo_flush_pulse,
  output logic [CAP_W-1:0]          txfifo_capacity,
  output logic                      diagnostic_control_reg_ro_override
);

  // Parameter sanity
  if (ADDR_W < 8 || CAP_W != 7 || NEAR_FULL_GAP < 1 || NEAR_EMPTY_GAP < 1
      || NEAR_FULL_GAP > 19 || NEAR_EMPTY_GAP > 19) begin : g_bad_param
    $error("lpa_regs: unsupported parameter value");
  end

  localparam logic [6:0] NF_GAP = 7'(NEAR_FULL_GAP);
  localparam logic [6:0] NE_GAP = 7'(NEAR_EMPTY_GAP);

  lpa_pkg::lpa_state_t s_ff;
  lpa_pkg::lpa_state_t nxt_s;
  logic                host_we;

  // Reset image of the state
  function automatic lpa_pkg::lpa_state_t reset_state();
    lpa_pkg::lpa_state_t r;
    r           = '0;
    r.expected_txn_code = `LPA_TCODE_OFF;
    r.f_empty   = 1'b1;
    r.capacity  = `LPA_SIZE_RST;
    return r;
  endfunction : reset_state

  // Byte-lane merge of write data
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        m[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return m;
  endfunction : merge

  // Register images as seen by software
  function automatic logic [31:0] img_phy(input lpa_pkg::lpa_state_t s);
    logic [31:0] v;
    v                               = '0;
    v[`LPA_PA_RDREQ]                = s.rd_req;
    v[`LPA_PA_WRREQ]                = s.wr_req;
    v[`LPA_PA_ADR_LSB +: 4]         = s.tgt_addr;
    v[`LPA_PA_WDAT_LSB +: 8]        = s.wr_val;
    v[`LPA_PA_RADR_LSB +: 4]        = s.ret_addr;
    v[`LPA_PA_RDAT_LSB +: 8]        = s.ret_val;
    return v;
  endfunction : img_phy

  function automatic logic [31:0] img_exp(input lpa_pkg::lpa_state_t s);
    logic [31:0] v;
    v                               = '0;
    v[`LPA_ER_LABEL_LSB +: 6]       = s.expected_label;
    v[`LPA_ER_TCODE_LSB +: 4]       = s.expected_txn_code;
    return v;
  endfunction : img_exp

  function automatic logic [31:0] img_fifo(input lpa_pkg::lpa_state_t s);
    logic [31:0] v;
    v                               = '0;
    v[`LPA_FS_FULL]                 = s.f_full;
    v[`LPA_FS_NFULL]                = s.f_nfull;
    v[`LPA_FS_FOUR]                 = s.f_four;
    v[`LPA_FS_NEMPTY]               = s.f_nempty;
    v[`LPA_FS_EMPTY]                = s.f_empty;
    v[`LPA_FS_FLUSH]                = s.flush;
    v[`LPA_FS_SIZE_LSB +: 7]        = s.capacity;
    return v;
  endfunction : img_fifo

  // Address decode shared by both channels; bit 32 marks a mapped slot
  function automatic logic [32:0] decode(input logic [7:0] a, input lpa_pkg::lpa_state_t s);
    logic [32:0] d;
    d = '0;
    unique case (a)
      `LPA_OFF_DIAGNOSTIC_CONTROL_REG:      d = {1'b1, 32'(s.diagnostic_control_reg_ovr) << `LPA_DIAGNOSTIC_CONTROL_REG_OVR};
      `LPA_OFF_PHY_ACC:   d = {1'b1, img_phy(s)};
      `LPA_OFF_EXP_RSP:   d = {1'b1, img_exp(s)};
      `LPA_OFF_RSVD_A,
      `LPA_OFF_RSVD_B:    d = {1'b1, 32'h0};
      `LPA_OFF_FIFO_STAT: d = {1'b1, img_fifo(s)};
      default:            d = '0;
    endcase
    return d;
  endfunction : decode

  assign host_we = s_ff.aw_have && s_ff.w_have && !s_ff.bvalid;

  // Next-state logic
  always_comb begin
    logic [31:0] wv;
    logic [32:0] dec;
    wv                = '0;
    dec               = '0;
    nxt_s             = s_ff;
    nxt_s.rsp_match   = 1'b0;
    nxt_s.flush_pulse = 1'b0;
    // Write address and data taken in either order
    if (s_axi_awvalid && s_ff.awready) begin
      nxt_s.aw_have = 1'b1;
      nxt_s.awaddr  = s_axi_awaddr[7:0];
    end
    if (s_axi_wvalid && s_ff.wready) begin
      nxt_s.w_have = 1'b1;
      nxt_s.wdata  = s_axi_wdata;
      nxt_s.wstrb  = s_axi_wstrb;
    end
    if (s_ff.bvalid && s_axi_bready) begin
      nxt_s.bvalid = 1'b0;
    end
    // Physical-layer request handshake and issue
    if (s_ff.phy_req.valid && phy_req_ready) begin
      nxt_s.phy_req.valid = 1'b0;
      if (s_ff.phy_req.write) begin
        nxt_s.wr_req = 1'b0;
      end else begin
        nxt_s.rd_req = 1'b0;
      end
    end else if (!s_ff.phy_req.valid && (s_ff.rd_req || s_ff.wr_req)) begin
      nxt_s.phy_req.valid = 1'b1;
      nxt_s.phy_req.write = !s_ff.rd_req;
      nxt_s.phy_req.addr  = s_ff.tgt_addr;
      nxt_s.phy_req.data  = s_ff.wr_val;
    end
    // Flush bit lasts one cycle and fires the pulse
    if (s_ff.flush) begin
      nxt_s.flush       = 1'b0;
      nxt_s.flush_pulse = 1'b1;
    end
    // Occupancy flags track the FIFO unless software owns them; sums widened against wrap
    if (!s_ff.diagnostic_control_reg_ovr) begin
      nxt_s.f_full   = fifo_level >= s_ff.capacity;
      nxt_s.f_nfull  = 8'(fifo_level) + 8'(NF_GAP) >= 8'(s_ff.capacity);
      nxt_s.f_four   = 8'(fifo_level) + 8'(`LPA_FREE_MIN) <= 8'(s_ff.capacity);
      nxt_s.f_nempty = fifo_level <= NE_GAP;
      nxt_s.f_empty  = fifo_level == '0;
    end
    // Register write once both halves are held
    if (host_we) begin
      dec           = decode(s_ff.awaddr, s_ff);
      wv            = merge(dec[31:0], s_ff.wdata, s_ff.wstrb);
      nxt_s.aw_have = 1'b0;
      nxt_s.w_have  = 1'b0;
      nxt_s.bvalid  = 1'b1;
      nxt_s.bresp   = dec[32] ? `LPA_RESP_OKAY : `LPA_RESP_SLVERR;
      unique case (s_ff.awaddr)
        `LPA_OFF_DIAGNOSTIC_CONTROL_REG: begin
          nxt_s.diagnostic_control_reg_ovr = wv[`LPA_DIAGNOSTIC_CONTROL_REG_OVR];
        end
        `LPA_OFF_PHY_ACC: begin
          if (wv[`LPA_PA_RDREQ]) begin
            nxt_s.rd_req = 1'b1;
          end
          if (wv[`LPA_PA_WRREQ]) begin
            nxt_s.wr_req = 1'b1;
          end
          nxt_s.tgt_addr = wv[`LPA_PA_ADR_LSB +: 4];
          nxt_s.wr_val   = wv[`LPA_PA_WDAT_LSB +: 8];
          if (s_ff.diagnostic_control_reg_ovr) begin
            nxt_s.ret_addr = wv[`LPA_PA_RADR_LSB +: 4];
            nxt_s.ret_val  = wv[`LPA_PA_RDAT_LSB +: 8];
          end
        end
        `LPA_OFF_EXP_RSP: begin
          nxt_s.expected_label = wv[`LPA_ER_LABEL_LSB +: 6];
          nxt_s.expected_txn_code = wv[`LPA_ER_TCODE_LSB +: 4];
        end
        `LPA_OFF_FIFO_STAT: begin
          if (s_ff.diagnostic_control_reg_ovr) begin
            nxt_s.f_full   = wv[`LPA_FS_FULL];
            nxt_s.f_nfull  = wv[`LPA_FS_NFULL];
            nxt_s.f_four   = wv[`LPA_FS_FOUR];
            nxt_s.f_nempty = wv[`LPA_FS_NEMPTY];
            nxt_s.f_empty  = wv[`LPA_FS_EMPTY];
          end
          if (wv[`LPA_FS_FLUSH]) begin
            nxt_s.flush = 1'b1;
          end
          nxt_s.capacity = wv[`LPA_FS_SIZE_LSB +: 7];
        end
        default: begin
        end
      endcase
    end
    // Read answer the cycle after the address is taken
    if (s_ff.rvalid && s_axi_rready) begin
      nxt_s.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_ff.arready) begin
      dec          = decode(s_axi_araddr[7:0], s_ff);
      nxt_s.rvalid = 1'b1;
      nxt_s.rdata  = dec[31:0];
      nxt_s.rresp  = dec[32] ? `LPA_RESP_OKAY : `LPA_RESP_SLVERR;
    end
    // Read answer from the physical layer wins over a host write
    if (phy_rsp.valid) begin
      nxt_s.ret_addr = phy_rsp.addr;
      nxt_s.ret_val  = phy_rsp.data;
    end
    // Expected response comparator
    nxt_s.rsp_match = rsp_pkt.valid && s_ff.expected_txn_code != `LPA_TCODE_OFF
                      && rsp_pkt.label == s_ff.expected_label
                      && rsp_pkt.tcode == s_ff.expected_txn_code;
    // Bus reset returns the filter and FIFO status flags to their defaults; capacity is kept
    if (bus_reset) begin
      nxt_s.expected_label = '0;
      nxt_s.expected_txn_code = `LPA_TCODE_OFF;
      nxt_s.f_full    = 1'b0;
      nxt_s.f_nfull   = 1'b0;
      nxt_s.f_four    = 1'b0;
      nxt_s.f_nempty  = 1'b0;
      nxt_s.f_empty   = 1'b1;
      nxt_s.flush     = 1'b0;
    end
    // Software reset clears registers but leaves bus channels alone
    if (sw_reset) begin
      nxt_s.diagnostic_control_reg_ovr  = 1'b0;
      nxt_s.rd_req    = 1'b0;
      nxt_s.wr_req    = 1'b0;
      nxt_s.tgt_addr  = '0;
      nxt_s.wr_val    = '0;
      nxt_s.ret_addr  = '0;
      nxt_s.ret_val   = '0;
      nxt_s.expected_label = '0;
      nxt_s.expected_txn_code = `LPA_TCODE_OFF;
      nxt_s.f_full    = 1'b0;
      nxt_s.f_nfull   = 1'b0;
      nxt_s.f_four    = 1'b0;
      nxt_s.f_nempty  = 1'b0;
      nxt_s.f_empty   = 1'b1;
      nxt_s.flush     = 1'b0;
      nxt_s.capacity  = `LPA_SIZE_RST;
      nxt_s.phy_req   = '0;
    end
    // Ready flags follow channel occupancy
    nxt_s.awready = !nxt_s.aw_have && !nxt_s.bvalid;
    nxt_s.wready  = !nxt_s.w_have && !nxt_s.bvalid;
    nxt_s.arready = !nxt_s.rvalid;
  end

  // State register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_ff <= reset_state();
    end else begin
      s_ff <= nxt_s;
    end
  end

  // Outputs straight from the state register
  assign s_axi_awready      = s_ff.awready;
  assign s_axi_wready       = s_ff.wready;
  assign s_axi_bvalid       = s_ff.bvalid;
  assign s_axi_bresp        = s_ff.bresp;
  assign s_axi_arready      = s_ff.arready;
  assign s_axi_rvalid       = s_ff.rvalid;
  assign s_axi_rdata        = s_ff.rdata;
  assign s_axi_rresp        = s_ff.rresp;
  assign phy_req            = s_ff.phy_req;
  assign rsp_match          = s_ff.rsp_match;
  assign txfifo_flush_pulse = s_ff.flush_pulse;
  assign txfifo_capacity    = s_ff.capacity;
  assign diagnostic_control_reg_ro_override   = s_ff.diagnostic_control_reg_ovr;
  // Checks
  property p_rd_clear;
    @(posedge aclk) disable iff (!aresetn)
    s_ff.phy_req.valid && phy_req_ready && !s_ff.phy_req.write && !host_we |=> !s_ff.rd_req;
  endproperty
  a_rd_clear: assert property (p_rd_clear) else $error("read request bit not cleared");
  property p_wr_issue;
    @(posedge aclk) disable iff (!aresetn)
    !s_ff.phy_req.valid && s_ff.wr_req && !s_ff.rd_req && !sw_reset
    |=> phy_req.valid && phy_req.write && phy_req.addr == $past(s_ff.tgt_addr)
        && phy_req.data == $past(s_ff.wr_val);
  endproperty
  a_wr_issue: assert property (p_wr_issue) else $error("write request not issued");
  property p_capture;
    @(posedge aclk) disable iff (!aresetn)
    phy_rsp.valid && !sw_reset
    |=> s_ff.ret_addr == $past(phy_rsp.addr) && s_ff.ret_val == $past(phy_rsp.data);
  endproperty
  a_capture: assert property (p_capture) else $error("returned register not captured");
  property p_ro_hold;
    @(posedge aclk) disable iff (!aresetn)
    !s_ff.diagnostic_control_reg_ovr && !phy_rsp.valid && !sw_reset |=> $stable(s_ff.ret_val);
  endproperty
  a_ro_hold: assert property (p_ro_hold) else $error("returned value changed");
  property p_match;
    @(posedge aclk) disable iff (!aresetn)
    rsp_pkt.valid && rsp_pkt.label == s_ff.expected_label && rsp_pkt.tcode == s_ff.expected_txn_code
    |=> rsp_match == ($past(s_ff.expected_txn_code) != `LPA_TCODE_OFF);
  endproperty
  a_match: assert property (p_match) else $error("response match wrong");
  property p_bus_reset;
    @(posedge aclk) disable iff (!aresetn)
    bus_reset |=> s_ff.expected_label == '0 && s_ff.expected_txn_code == `LPA_TCODE_OFF && s_ff.f_empty
                  && !s_ff.f_full ##1 !rsp_match;
  endproperty
  a_bus_reset: assert property (p_bus_reset) else $error("bus reset defaults wrong");
  property p_full;
    @(posedge aclk) disable iff (!aresetn)
    !s_ff.diagnostic_control_reg_ovr && !bus_reset && !sw_reset
    |=> s_ff.f_full == ($past(fifo_level) >= $past(s_ff.capacity))
        && s_ff.f_empty == ($past(fifo_level) == '0);
  endproperty
  a_full: assert property (p_full) else $error("full or empty flag wrong");
  property p_four;
    @(posedge aclk) disable iff (!aresetn)
    !s_ff.diagnostic_control_reg_ovr && !bus_reset && !sw_reset
    |=> s_ff.f_four == (8'($past(fifo_level)) + 8'(`LPA_FREE_MIN) <= 8'($past(s_ff.capacity)))
        && s_ff.f_nfull == (8'($past(fifo_level)) + 8'(NF_GAP) >= 8'($past(s_ff.capacity)));
  endproperty
  a_four: assert property (p_four) else $error("four-free or near-full flag wrong");
  property p_flush;
    @(posedge aclk) disable iff (!aresetn)
    s_ff.flush |=> txfifo_flush_pulse ##1 !txfifo_flush_pulse || $past(s_ff.flush);
  endproperty
  a_flush: assert property (p_flush) else $error("flush pulse wrong");
  property p_soft;
    @(posedge aclk) disable iff (!aresetn)
    sw_reset |=> txfifo_capacity == `LPA_SIZE_RST && !s_ff.rd_req && !s_ff.wr_req;
  endproperty
  a_soft: assert property (p_soft) else $error("software reset defaults wrong");
endmodule : lpa_regs
`default_nettype wire

// ### verilog/lpa_defs.svh
`ifndef LPA_DEFS_SVH
`define LPA_DEFS_SVH

// Register byte offsets
`define LPA_OFF_DIAGNOSTIC_CONTROL_REG      8'h30
`define LPA_OFF_PHY_ACC   8'h34
`define LPA_OFF_EXP_RSP   8'h38
`define LPA_OFF_RSVD_A    8'h3c
`define LPA_OFF_RSVD_B    8'h40
`define LPA_OFF_FIFO_STAT 8'h44

// Diagnostic control fields
`define LPA_DIAGNOSTIC_CONTROL_REG_OVR      4

// Physical-layer access fields
`define LPA_PA_RDREQ      0
`define LPA_PA_WRREQ      1
`define LPA_PA_ADR_LSB    4
`define LPA_PA_WDAT_LSB   8
`define LPA_PA_RADR_LSB   20
`define LPA_PA_RDAT_LSB   24

// Expected response fields
`define LPA_ER_LABEL_LSB  16
`define LPA_ER_TCODE_LSB  24
`define LPA_TCODE_OFF     4'hf

// Transmit FIFO status fields
`define LPA_FS_FULL       0
`define LPA_FS_NFULL      1
`define LPA_FS_FOUR       4
`define LPA_FS_NEMPTY     14
`define LPA_FS_EMPTY      15
`define LPA_FS_FLUSH      17
`define LPA_FS_SIZE_LSB   25
`define LPA_SIZE_RST      7'h14
`define LPA_FREE_MIN      7'h04

// Bus answers
`define LPA_RESP_OKAY     2'h0
`define LPA_RESP_SLVERR   2'h2

`endif

// ### verilog/lpa_pkg.sv
package lpa_pkg;

  // Request towards the physical layer
  typedef struct packed {
    logic       valid;
    logic       write;
    logic [3:0] addr;
    logic [7:0] data;
  } lpa_phy_req_t;

  // Register read answer from the physical layer
  typedef struct packed {
    logic       valid;
    logic [3:0] addr;
    logic [7:0] data;
  } lpa_phy_rsp_t;

  // Header fields of an incoming response packet
  typedef struct packed {
    logic       valid;
    logic [5:0] label;
    logic [3:0] tcode;
  } lpa_rsp_pkt_t;

  // Whole state of the register block
  typedef struct packed {
    logic         awready;
    logic         wready;
    logic         bvalid;
    logic [1:0]   bresp;
    logic         aw_have;
    logic         w_have;
    logic [7:0]   awaddr;
    logic [31:0]  wdata;
    logic [3:0]   wstrb;
    logic         arready;
    logic         rvalid;
    logic [1:0]   rresp;
    logic [31:0]  rdata;
    logic         diagnostic_control_reg_ovr;
    logic         rd_req;
    logic         wr_req;
    logic [3:0]   tgt_addr;
    logic [7:0]   wr_val;
    logic [3:0]   ret_addr;
    logic [7:0]   ret_val;
    logic [5:0]   expected_label;
    logic [3:0]   expected_txn_code;
    logic         f_full;
    logic         f_nfull;
    logic         f_four;
    logic         f_nempty;
    logic         f_empty;
    logic         flush;
    logic [6:0]   capacity;
    lpa_phy_req_t phy_req;
    logic         rsp_match;
    logic         flush_pulse;
  } lpa_state_t;

endpackage : lpa_pkg

// ### testbench/lpa_phy_model.sv
`timescale 1ns/1ns
`default_nettype none
module lpa_phy_model (
  // Clock and reset
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  // Pace of acceptance
  input  wire logic                  slow,
  // Request and read answer
  input  wire lpa_pkg::lpa_phy_req_t phy_req,
  output logic                       phy_req_ready,
  output lpa_pkg::lpa_phy_rsp_t      phy_rsp
);
  logic [7:0] mem [16];
  logic [1:0] dly;
  logic       pend;
  logic [3:0] radr;

  // Accepts requests, keeps a register file, answers reads a cycle later
  always_ff @(posedge aclk) begin
    phy_req_ready <= 1'b0;
    phy_rsp       <= {1'b0, ~phy_rsp.addr, ~phy_rsp.data}; // Idle lines keep toggling
    if (!aresetn) begin
      phy_rsp <= '0;
      pend    <= 1'b0;
      dly     <= 2'h0;
      for (int i = 0; i < 16; i++) mem[i] <= 8'ha0 + 8'(i);
    end else begin
      if (phy_req.valid && phy_req_ready) begin
        dly  <= 2'h0;
        pend <= !phy_req.write;
        radr <= phy_req.addr;
        if (phy_req.write) mem[phy_req.addr] <= phy_req.data;
      end else if (phy_req.valid) begin
        dly           <= dly + 2'h1;
        phy_req_ready <= !slow || dly == 2'h3; // Slow mode stalls three cycles
      end
      if (pend) begin
        phy_rsp <= {1'b1, radr, mem[radr]};
        pend    <= 1'b0;
      end
    end
  end
endmodule : lpa_phy_model
`default_nettype wire

// ### testbench/link_phy_access_and_txfifo_regs_tb.sv
`timescale 1ns/1ns
`default_nettype none
module link_phy_access_and_txfifo_regs_tb;
  logic                  aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic                  sw_reset, bus_reset, slow, awready, wready, bvalid, arready, rvalid;
  logic                  phy_req_ready, rsp_match, flush_pulse, ovr;
  logic [7:0]            awaddr, araddr;
  logic [31:0]           wdata, rdata, seed, d;
  logic [3:0]            wstrb;
  logic [1:0]            bresp, rresp, last_resp;
  logic [6:0]            fifo_level, capacity;
  lpa_pkg::lpa_phy_req_t phy_req;
  lpa_pkg::lpa_phy_rsp_t phy_rsp;
  lpa_pkg::lpa_rsp_pkt_t rsp_pkt;
  int                    error_cnt, comparisons, cyc, flushes, cap, lvl, a, v, l, t, ret;
  int                    lv [8];

  lpa_regs u_lpa_regs (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .sw_reset(sw_reset), .bus_reset(bus_reset), .phy_req(phy_req),
    .phy_req_ready(phy_req_ready), .phy_rsp(phy_rsp), .rsp_pkt(rsp_pkt),
    .rsp_match(rsp_match), .fifo_level(fifo_level), .txfifo_flush_pulse(flush_pulse),
    .txfifo_capacity(capacity), .diagnostic_control_reg_ro_override(ovr));
  lpa_phy_model u_lpa_phy_model (.aclk(aclk), .aresetn(aresetn), .slow(slow),
    .phy_req(phy_req), .phy_req_ready(phy_req_ready), .phy_rsp(phy_rsp));

  // Clock, watchdog and flush pulse counter
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cyc++;
    if (flush_pulse === 1'b1) flushes++;
    if (cyc == 20000) begin
      error_cnt++;
      finish_test();
    end
  end

  function automatic int xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return int'(seed & 32'h7fffffff);
  endfunction : xs

  // Expected status word from occupancy and capacity
  function automatic logic [31:0] stat(input int q, input int c);
    stat = 32'(c) << 25;
    stat[0] = q >= c;
    stat[1] = q + 1 >= c;
    stat[4] = q + 4 <= c;
    stat[14] = q <= 1;
    stat[15] = q == 0;
  endfunction : stat

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Bus write; bready stays high so the answer is taken at once
  task automatic wr(input logic [7:0] ad, input logic [31:0] dt, input logic [3:0] s = 4'hf);
    awaddr <= ad;
    wdata <= dt;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    last_resp = bresp;
  endtask : wr

  task automatic rd(input logic [7:0] ad);
    araddr <= ad;
    arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    last_resp = rresp;
  endtask : rd

  task automatic exp_reg(input logic [7:0] ad, input logic [31:0] e);
    rd(ad);
    check($sformatf("reg %h", ad), d, e);
  endtask : exp_reg

  task automatic pkt(input int pl, input int pt, input logic e);
    rsp_pkt <= {1'b1, 6'(pl), 4'(pt)};
    @(posedge aclk);
    rsp_pkt.valid <= 1'b0;
    @(negedge aclk);
    check("match", 32'(rsp_match), 32'(e));
    @(posedge aclk);
  endtask : pkt

  task automatic finish_test;
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : finish_test

  // Main sequence
  initial begin
    {awvalid, wvalid, arvalid, sw_reset, bus_reset, slow, aresetn} = '0;
    {bready, rready} = 2'b11;
    {awaddr, araddr, wdata, wstrb, fifo_level, rsp_pkt} = '0;
    seed = 32'hda74;
    cap = 20;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    check("capacity", 32'(capacity), 32'h14);
    check("override", 32'(ovr), 32'h0);
    exp_reg(8'h34, 32'h0);
    exp_reg(8'h38, 32'h0f000000);
    exp_reg(8'h44, stat(0, 20));
    wr(8'h40, 32'hffffffff);
    check("resp", 32'(last_resp), 32'h0);
    exp_reg(8'h40, 32'h0);
    exp_reg(8'h3c, 32'h0);
    wr(8'h50, 32'hffffffff);
    check("resp", 32'(last_resp), 32'h2);
    rd(8'h35);
    check("resp", 32'(last_resp), 32'h2);
    // Occupancy sweep at the set edge of every threshold, and both edges of full and empty
    for (int k = 0; k < 2; k++) begin
      if (k == 1) begin
        cap = 5 + xs() % 100;
        wr(8'h44, 32'(cap) << 25, 4'h8);
        check("capacity", 32'(capacity), 32'(cap));
      end
      lv = '{0, 1, 4, cap - 5, cap - 4, cap - 1, cap, xs() % 128};
      foreach (lv[i]) begin
        lvl = lv[i];
        fifo_level <= 7'(lvl);
        repeat (2) @(posedge aclk);
        exp_reg(8'h44, stat(lvl, cap));
      end
    end
    // Physical-layer write then read back, prompt and slow
    for (int k = 0; k < 2; k++) begin
      slow <= 1'(k);
      a = xs() % 16;
      v = xs() % 256;
      wr(8'h34, 32'(v << 8 | a << 4 | 2));
      do rd(8'h34); while (d[1]);
      wr(8'h34, 32'(a << 4 | 1));
      do rd(8'h34); while (d[0]);
      repeat (4) @(posedge aclk);
      ret = v << 24 | a << 20;
      exp_reg(8'h34, 32'(ret | a << 4));
    end
    // Returned fields and flags under the override
    wr(8'h34, 32'hfff00000);
    exp_reg(8'h34, 32'(ret));
    wr(8'h30, 32'h10);
    check("override", 32'(ovr), 32'h1);
    wr(8'h34, 32'h5a700000);
    exp_reg(8'h34, 32'h5a700000);
    wr(8'h44, 32'h0000c013 | 32'(cap) << 25);
    exp_reg(8'h44, 32'h0000c013 | 32'(cap) << 25);
    wr(8'h30, 32'h0);
    repeat (2) @(posedge aclk);
    exp_reg(8'h44, stat(lvl, cap));
    flushes = 0;
    wr(8'h44, 32'h00020000, 4'h4);
    repeat (3) @(posedge aclk);
    check("flushes", 32'(flushes), 32'h1);
    exp_reg(8'h44, stat(lvl, cap));
    // Response filter
    pkt(0, 15, 1'b0);
    l = xs() % 64;
    t = xs() % 15;
    wr(8'h38, 32'(t << 24 | l << 16));
    pkt(l, t, 1'b1);
    pkt(l ^ 1, t, 1'b0);
    pkt(l, (t + 1) % 15, 1'b0);
    // Bus reset then software reset
    bus_reset <= 1'b1;
    @(posedge aclk);
    bus_reset <= 1'b0;
    @(posedge aclk);
    exp_reg(8'h38, 32'h0f000000);
    check("capacity", 32'(capacity), 32'(cap));
    exp_reg(8'h34, 32'h5a700000);
    sw_reset <= 1'b1;
    @(posedge aclk);
    sw_reset <= 1'b0;
    @(posedge aclk);
    exp_reg(8'h34, 32'h0);
    check("capacity", 32'(capacity), 32'h14);
    exp_reg(8'h44, stat(lvl, 20));
    finish_test();
  end
endmodule : link_phy_access_and_txfifo_regs_tb
`default_nettype wire
